// [src/sto_pkg.sv]
package sto_pkg;
	// self-check pulse test: drive test stimulus, wait, then expect the readback
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned CHECK_SETTLE_US = 10;
	localparam int unsigned CHECK_SETTLE_CYC = CHECK_SETTLE_US * CLK_MHZ;
	localparam int unsigned CHECK_TIMEOUT_US = 100;
	localparam int unsigned CHECK_TIMEOUT_CYC = CHECK_TIMEOUT_US * CLK_MHZ;
	localparam int unsigned CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [1:0] PAIR_BOTH = 2'b11;
	typedef enum logic [2:0] {
		STO_ST_IDLE,
		STO_ST_TEST_LOW,
		STO_ST_TEST_HIGH,
		STO_ST_READY,
		STO_ST_FAULT
	} sto_state_t;
endpackage : sto_pkg

// [src/sto_sync.sv]
`timescale 1ns/10ps
// two-stage synchroniser for pin inputs
module sto_sync #(
	parameter int unsigned WIDTH = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			stage1_reg <= '0;
			sync_out <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out <= stage1_reg;
		end
	end
endmodule : sto_sync

// [src/sto_interlock.sv]
`timescale 1ns/10ps
// Overview of operation
// - with the feature enabled, inputs five and six become safe-off channels a and b
// - power stage energized only while both safe-off channels are high together
// - self-check of the safe-off path runs after every power-on before energizing
// - self-check reruns whenever the channel pair moves into both-high
// - outputs energized only after the latest self-check passed
// - a floating or low channel disables the power outputs
// - safe-off forces no torque whatever the controller's own state or faults
// - on safe-off all phase drivers go off so the motor coasts, no braking
// - no setting bypasses the check; both channels high always needed when fitted
// - the two lines stay readable as general inputs five and six
// - without the option the lines are plain inputs with no gating effect
module sto_interlock #(
	parameter int unsigned SETTLE_CYC = sto_pkg::CHECK_SETTLE_CYC,
	parameter int unsigned TIMEOUT_CYC = sto_pkg::CHECK_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// option strap, sampled each cycle; stable in practice
	input wire logic safe_torque_off_fitted,
	// connector lines after the threshold comparators (high = 6..30 V band)
	input wire logic safe_off_channel_a,
	input wire logic safe_off_channel_b,
	// self-check stimulus and readback of the hardware cut-off path
	output logic self_check_test_en,
	input wire logic self_check_readback,
	// motor control core request and bridge gate enables
	input wire logic core_drive_req,
	input wire logic [5:0] core_gate_cmd,
	output logic [5:0] gate_enable,
	// general-purpose views of the same lines
	output logic general_digital_input_five,
	output logic general_digital_input_six,
	// status
	output logic torque_permitted,
	output logic self_check_busy,
	output logic self_check_fault
);
	logic [1:0] pair_sync;
	logic [1:0] pair_prev_reg;
	logic both_high;
	logic enter_both_high;
	sto_pkg::sto_state_t state_reg;
	logic [sto_pkg::CNT_W-1:0] cnt_reg;
	logic fault_reg;
	logic settle_done;
	logic timeout;

	// one decode of the test phases, shared by the test drive and the busy flag
	function automatic logic in_state(input sto_pkg::sto_state_t cur,
		input sto_pkg::sto_state_t want);
		in_state = (cur == want);
	endfunction : in_state

	sto_sync #(
		.WIDTH(2)
	) u_sync (
		.clk(clk),
		.nrst(nrst),
		.async_in({safe_off_channel_b, safe_off_channel_a}),
		.sync_out(pair_sync)
	);

	// inputs five and six stay readable in both variants
	always_ff @(posedge clk) begin
		if (!nrst) begin
			general_digital_input_five <= 1'b0;
			general_digital_input_six <= 1'b0;
		end else begin
			general_digital_input_five <= pair_sync[0];
			general_digital_input_six <= pair_sync[1];
		end
	end

	// a floating line reads low through the comparator, so it counts as off
	assign both_high = (pair_sync == sto_pkg::PAIR_BOTH);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pair_prev_reg <= '0;
		end else begin
			pair_prev_reg <= pair_sync;
		end
	end

	// prev reset to 00 means the first both-high after reset also starts a check
	assign enter_both_high = both_high && (pair_prev_reg != sto_pkg::PAIR_BOTH);

	assign settle_done = (cnt_reg >= sto_pkg::CNT_W'(SETTLE_CYC));
	assign timeout = (cnt_reg >= sto_pkg::CNT_W'(TIMEOUT_CYC));

	// check sequence: pull the cut-off low and expect readback low,
	// then release and expect readback to follow the channels high
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg <= sto_pkg::STO_ST_IDLE;
			cnt_reg <= sto_pkg::CNT_ZERO;
		end else if (!safe_torque_off_fitted) begin
			state_reg <= sto_pkg::STO_ST_IDLE;
			cnt_reg <= sto_pkg::CNT_ZERO;
		end else if (!both_high) begin
			// dropping out aborts any check; a fresh one runs on re-entry
			state_reg <= (state_reg == sto_pkg::STO_ST_FAULT) ?
				sto_pkg::STO_ST_FAULT : sto_pkg::STO_ST_IDLE;
			cnt_reg <= sto_pkg::CNT_ZERO;
		end else if (enter_both_high) begin
			state_reg <= sto_pkg::STO_ST_TEST_LOW;
			cnt_reg <= sto_pkg::CNT_ZERO;
		end else begin
			case (state_reg)
				sto_pkg::STO_ST_TEST_LOW: begin
					if (settle_done && !self_check_readback) begin
						state_reg <= sto_pkg::STO_ST_TEST_HIGH;
						cnt_reg <= sto_pkg::CNT_ZERO;
					end else if (timeout) begin
						state_reg <= sto_pkg::STO_ST_FAULT;
						cnt_reg <= sto_pkg::CNT_ZERO;
					end else begin
						cnt_reg <= cnt_reg + sto_pkg::CNT_ONE;
					end
				end
				sto_pkg::STO_ST_TEST_HIGH: begin
					if (settle_done && self_check_readback) begin
						state_reg <= sto_pkg::STO_ST_READY;
						cnt_reg <= sto_pkg::CNT_ZERO;
					end else if (timeout) begin
						state_reg <= sto_pkg::STO_ST_FAULT;
						cnt_reg <= sto_pkg::CNT_ZERO;
					end else begin
						cnt_reg <= cnt_reg + sto_pkg::CNT_ONE;
					end
				end
				sto_pkg::STO_ST_READY: begin
					state_reg <= sto_pkg::STO_ST_READY;
				end
				sto_pkg::STO_ST_FAULT: begin
					// held until the pair leaves and re-enters both-high
					state_reg <= sto_pkg::STO_ST_FAULT;
				end
				default: begin
					// idle while both high without an entry edge cannot pass unchecked
					state_reg <= sto_pkg::STO_ST_IDLE;
					cnt_reg <= sto_pkg::CNT_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			fault_reg <= 1'b0;
		end else if (!safe_torque_off_fitted) begin
			fault_reg <= 1'b0;
		end else if (state_reg == sto_pkg::STO_ST_FAULT) begin
			fault_reg <= 1'b1;
		end else if (state_reg == sto_pkg::STO_ST_READY) begin
			fault_reg <= 1'b0;
		end
	end

	assign self_check_test_en = in_state(state_reg, sto_pkg::STO_ST_TEST_LOW);
	assign self_check_busy = in_state(state_reg, sto_pkg::STO_ST_TEST_LOW) ||
		in_state(state_reg, sto_pkg::STO_ST_TEST_HIGH);
	assign self_check_fault = fault_reg;

	// permission ignores core_drive_req on purpose: no core fault state may
	// release the cut-off, the core can only further withhold its gates
	assign torque_permitted = !safe_torque_off_fitted ||
		(both_high && (state_reg == sto_pkg::STO_ST_READY));

	// all six gates off together: bridge floats, motor coasts
	always_ff @(posedge clk) begin
		if (!nrst) begin
			gate_enable <= '0;
		end else if (torque_permitted && core_drive_req) begin
			gate_enable <= core_gate_cmd;
		end else begin
			gate_enable <= '0;
		end
	end
endmodule : sto_interlock

// [dv/sto_partner.sv]
`timescale 1ns/10ps
module sto_partner (
	input wire logic clk,
	input wire logic test_en,
	input wire logic broken,
	output logic readback
);
	// cut-off path lags the test pulse a clock; broken holds it low like a welded path
	always_ff @(posedge clk) begin
		readback <= !test_en && !broken;
	end
endmodule : sto_partner

// [dv/sto_chk_asserts.sv]
`timescale 1ns/10ps
module sto_chk (
	input wire logic clk, nrst, safe_torque_off_fitted, safe_off_channel_a, safe_off_channel_b,
	input wire logic self_check_test_en, self_check_readback, core_drive_req,
	input wire logic [5:0] core_gate_cmd, gate_enable,
	input wire logic general_digital_input_five, general_digital_input_six,
	input wire logic torque_permitted, self_check_busy, self_check_fault
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire both = safe_off_channel_a && safe_off_channel_b;
	sequence s_enter;
		safe_torque_off_fitted && both && !$past(both);
	endsequence
	sequence s_check;
		##[1:4] self_check_busy && self_check_test_en;
	endsequence
	a_entry_checks: assert property (s_enter |-> s_check)
		else $error("no self-check after entry");
	a_gate_gated: assert property (gate_enable != 6'h00 |-> $past(torque_permitted))
		else $error("gates on without permission");
	a_gate_follow: assert property ($past(nrst) && $past(torque_permitted && core_drive_req)
		|-> gate_enable == $past(core_gate_cmd))
		else $error("gates differ from command");
	a_coast_off: assert property (!torque_permitted |=> gate_enable == 6'h00)
		else $error("gates left on");
	a_low_kills: assert property (safe_torque_off_fitted && !both |-> ##[1:3] !torque_permitted)
		else $error("low channel kept torque");
	a_unfit_free: assert property (!safe_torque_off_fitted |-> torque_permitted)
		else $error("unfitted lines gate torque");
	a_gpio_copy: assert property ($past(nrst, 3) && $past(nrst, 2) && $past(nrst)
		|-> {general_digital_input_five, general_digital_input_six}
		== $past({safe_off_channel_a, safe_off_channel_b}, 3))
		else $error("general inputs wrong");
	a_busy_blocks: assert property (self_check_busy |-> !torque_permitted)
		else $error("torque during check");
	a_ready_after: assert property ($rose(torque_permitted) && safe_torque_off_fitted
		|-> $past(self_check_busy))
		else $error("torque without check");
	a_fault_sticky: assert property (self_check_fault && !torque_permitted |=> self_check_fault)
		else $error("fault dropped");
endmodule : sto_chk
bind sto_interlock sto_chk i_sto_chk (.*);

// [dv/safe_torque_off_interlock_test.sv]
`timescale 1ns/10ps
module safe_torque_off_interlock_test;
	logic clk = 0, nrst = 0, fit = 1, ch_a = 0, ch_b = 0, req = 1, broken = 0, ten, rb;
	logic g5, g6, perm, busy, fault;
	logic [5:0] cmd = 6'h2a, gate;
	int bad_count = 0, cmp_count = 0;
	always #4 clk = ~clk;
	sto_partner i_sto_partner (.clk(clk), .test_en(ten), .broken(broken), .readback(rb));
	sto_interlock #(.SETTLE_CYC(4), .TIMEOUT_CYC(20)) i_sto_interlock (.clk(clk), .nrst(nrst),
		.safe_torque_off_fitted(fit), .safe_off_channel_a(ch_a), .safe_off_channel_b(ch_b),
		.self_check_test_en(ten), .self_check_readback(rb), .core_drive_req(req),
		.core_gate_cmd(cmd), .gate_enable(gate), .general_digital_input_five(g5),
		.general_digital_input_six(g6), .torque_permitted(perm), .self_check_busy(busy),
		.self_check_fault(fault));
	task automatic wrap_up;
		if (bad_count == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [5:0] exp, input logic [5:0] act);
		cmp_count++;
		if (act !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %h vs %h", $time, exp, act);
		end
	endtask : chk
	task automatic chk1(input logic exp, input logic act);
		chk({5'h00, exp}, {5'h00, act});
	endtask : chk1
	// sample 1 ns after the edge so registered outputs have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic pins(input logic a, input logic b);
		@(posedge clk);
		ch_a <= a;
		ch_b <= b;
	endtask : pins
	task automatic wait_perm;
		repeat (100) if (perm !== 1'b1) cyc(1);
		chk1(1'b1, perm);
	endtask : wait_perm
	task automatic t_power_on;
		pins(1, 1);
		cyc(4);
		chk1(1'b1, busy);
		chk1(1'b0, perm);
		wait_perm;
		cyc(1);
		chk(cmd, gate);
	endtask : t_power_on
	task automatic t_drop;
		pins(0, 1);
		cyc(4);
		chk1(1'b0, perm);
		chk(6'h00, gate);
		chk({5'h00, g5}, {5'h00, ~g6});
		pins(1, 1);
		cyc(4);
		chk1(1'b1, busy);
		wait_perm;
	endtask : t_drop
	task automatic t_fault;
		@(posedge clk) broken <= 1;
		pins(0, 0);
		pins(1, 1);
		cyc(60);
		chk1(1'b1, fault);
		chk(6'h00, gate);
		@(posedge clk) broken <= 0;
		pins(0, 0);
		pins(1, 1);
		wait_perm;
		cyc(1);
		chk1(1'b0, fault);
	endtask : t_fault
	task automatic t_unfit;
		@(posedge clk) fit <= 0;
		pins(0, 0);
		cyc(4);
		chk1(1'b1, perm);
		chk(cmd, gate);
		chk1(1'b0, g5);
	endtask : t_unfit
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1;
		t_power_on;
		t_drop;
		t_fault;
		t_unfit;
		wrap_up;
	end
	initial begin
		#20000;
		bad_count++;
		wrap_up;
	end
endmodule : safe_torque_off_interlock_test
